/* File: rtl/pst_top.sv */
`timescale 1ns/1ps
module pst_top
    import pst_pkg::*;
#(
    parameter int unsigned HOLDOFF_CYCLES = HOLDOFF_CYC,
    parameter int unsigned EXPIRE_CYCLES  = 32'(EXPIRE_CYC_L),
    parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC,
    parameter int unsigned MIN_CYCLES     = MIN_CYC
) (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [2:0] start_cmp_first,
    input  wire logic [2:0] start_cmp_second,
    input  wire logic [2:0] stop_cmp_first,
    input  wire logic [2:0] stop_cmp_second,
    output logic            start_line,
    output logic            stop_line,
    output logic [6:0]      seg_q,
    output logic            dp_q,
    output logic [3:0]      digit_n_q
);

    function automatic logic chip_trigger(input logic [2:0] cmp,
                                          input logic       chain_in,
                                          input logic       cmp_en);
        chip_trigger = (cmp_en & |cmp) | chain_in;
    endfunction

    // Shift-and-add-3; five digits cover the full 14-bit range
    function automatic logic [19:0] to_bcd(input logic [SPEED_W-1:0] bin);
        logic [19:0] acc;
        acc = 20'h0_0000;
        for (int i = SPEED_W - 1; i >= 0; i--) begin
            for (int d = 0; d < 5; d++) begin
                if (acc[d*4 +: 4] > 4'h4) begin
                    acc[d*4 +: 4] = acc[d*4 +: 4] + 4'h3;
                end
            end
            acc = {acc[18:0], bin[i]};
        end
        to_bcd = acc;
    endfunction

    function automatic logic [6:0] seg_of(input logic [3:0] digit);
        unique case (digit)
            4'h0: seg_of = 7'h3f;
            4'h1: seg_of = 7'h06;
            4'h2: seg_of = 7'h5b;
            4'h3: seg_of = 7'h4f;
            4'h4: seg_of = 7'h66;
            4'h5: seg_of = 7'h6d;
            4'h6: seg_of = 7'h7d;
            4'h7: seg_of = 7'h07;
            4'h8: seg_of = 7'h7f;
            4'h9: seg_of = 7'h6f;
            default: seg_of = SEG_BLANK;
        endcase
    endfunction

    pst_state_t               state_q, state_d;
    logic                     cmp_en_q, cmp_en_d;
    logic                     start_prev_q, start_prev_d;
    logic                     stop_prev_q, stop_prev_d;
    logic [31:0]              cnt_q, cnt_d;
    logic [31:0]              expire_q, expire_d;
    logic [SPEED_NUM_W-1:0]   dvd_q, dvd_d;
    logic [SPEED_NUM_W-1:0]   quo_q, quo_d;
    logic [31:0]              rem_q, rem_d;
    logic [4:0]               step_q, step_d;
    logic [3:0]               digits_q [4];
    logic [3:0]               digits_d [4];
    logic                     dash_q, dash_d;
    logic                     dp_on_q, dp_on_d;

    logic                     start_chain;
    logic                     stop_chain;
    logic                     start_rise;
    logic                     stop_rise;
    logic [32:0]              rem_sh;
    logic [19:0]              bcd;

    // Unused chain input of the first chip behaves as pulled low
    assign start_chain = chip_trigger(start_cmp_first, 1'b0, cmp_en_q);
    assign stop_chain  = chip_trigger(stop_cmp_first, 1'b0, cmp_en_q);
    assign start_line  = chip_trigger(start_cmp_second, start_chain,
                                      cmp_en_q);
    assign stop_line   = chip_trigger(stop_cmp_second, stop_chain,
                                      cmp_en_q);

    // Edges only, so a long shadow on one sensor counts once
    assign start_rise  = start_line & ~start_prev_q;
    assign stop_rise   = stop_line & ~stop_prev_q;
    // Remainder shifted by one dividend bit for the restoring divider
    assign rem_sh      = {rem_q, dvd_q[SPEED_NUM_W-1]};
    assign bcd         = to_bcd(quo_q[SPEED_W-1:0]);

    always_comb begin
        state_d      = state_q;
        cmp_en_d     = cmp_en_q;
        start_prev_d = start_line;
        stop_prev_d  = stop_line;
        cnt_d        = cnt_q;
        expire_d     = expire_q;
        dvd_d        = dvd_q;
        quo_d        = quo_q;
        rem_d        = rem_q;
        step_d       = step_q;
        digits_d     = digits_q;
        dash_d       = dash_q;
        dp_on_d      = dp_on_q;

        // Result ageing; a fresh result below restarts it
        if (!dash_q) begin
            expire_d = expire_q + 32'h1;
            if (expire_q >= EXPIRE_CYCLES - 1) begin
                dash_d   = 1'b1;
                expire_d = 32'h0;
            end
        end

        unique case (state_q)
            PST_POR: begin
                // Lines stay low until the enable, so no false start
                cnt_d = cnt_q + 32'h1;
                if (cnt_q >= POR_CYC - 1) begin
                    cmp_en_d = 1'b1;
                    cnt_d    = 32'h0;
                    state_d  = PST_ARMED;
                end
            end
            PST_ARMED: begin
                // Only an edge starts a run, a line stuck high cannot
                if (start_rise) begin
                    cnt_d   = 32'h1;
                    state_d = PST_TIMING;
                end
            end
            PST_TIMING: begin
                cnt_d = cnt_q + 32'h1;
                if (stop_rise) begin
                    cnt_d = cnt_q;
                    if (cnt_q < MIN_CYCLES) begin
                        digits_d = '{default: 4'h0};
                        dash_d   = 1'b0;
                        dp_on_d  = 1'b0;
                        expire_d = 32'h0;
                        cnt_d    = 32'h0;
                        state_d  = PST_HOLD;
                    end else begin
                        dvd_d   = SPEED_NUM_W'(SPEED_NUM);
                        rem_d   = 32'h0;
                        quo_d   = '0;
                        step_d  = 5'h0;
                        state_d = PST_DIVIDE;
                    end
                end else if (cnt_q >= TIMEOUT_CYCLES) begin
                    // No hold-off: nothing was measured, re-arm at once
                    dash_d  = 1'b1;
                    cnt_d   = 32'h0;
                    state_d = PST_ARMED;
                end
            end
            PST_DIVIDE: begin
                // Bit-serial divide: slow but tiny, time is plentiful here
                dvd_d  = {dvd_q[SPEED_NUM_W-2:0], 1'b0};
                step_d = step_q + 5'h1;
                if (rem_sh >= {1'b0, cnt_q}) begin
                    rem_d = 32'(rem_sh - {1'b0, cnt_q});
                    quo_d = {quo_q[SPEED_NUM_W-2:0], 1'b1};
                end else begin
                    rem_d = rem_sh[31:0];
                    quo_d = {quo_q[SPEED_NUM_W-2:0], 1'b0};
                end
                if (step_q == 5'(SPEED_NUM_W - 1)) begin
                    state_d = PST_SHOW;
                end
            end
            PST_SHOW: begin
                // Five BCD digits; show the upper four above 999.9
                if (bcd[19:16] != 4'h0) begin
                    for (int i = 0; i < 4; i++) begin
                        digits_d[i] = bcd[(i+1)*4 +: 4];
                    end
                    dp_on_d = 1'b0;
                end else begin
                    for (int i = 0; i < 4; i++) begin
                        digits_d[i] = bcd[i*4 +: 4];
                    end
                    dp_on_d = 1'b1;
                end
                dash_d   = 1'b0;
                expire_d = 32'h0;
                cnt_d    = 32'h0;
                state_d  = PST_HOLD;
            end
            PST_HOLD: begin
                // Echoes of the same shot fall in here and are dropped
                cnt_d = cnt_q + 32'h1;
                if (cnt_q >= HOLDOFF_CYCLES - 1) begin
                    cnt_d   = 32'h0;
                    state_d = PST_ARMED;
                end
            end
            default: begin
                state_d = PST_POR;
            end
        endcase
    end

    // Synchronous reset stands in for power-on; display starts dashed
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q      <= PST_POR;
            cmp_en_q     <= 1'b0;
            start_prev_q <= 1'b0;
            stop_prev_q  <= 1'b0;
            cnt_q        <= 32'h0;
            expire_q     <= 32'h0;
            dvd_q        <= '0;
            quo_q        <= '0;
            rem_q        <= 32'h0;
            step_q       <= 5'h0;
            digits_q     <= '{default: 4'h0};
            dash_q       <= 1'b1;
            dp_on_q      <= 1'b0;
        end else begin
            state_q      <= state_d;
            cmp_en_q     <= cmp_en_d;
            start_prev_q <= start_prev_d;
            stop_prev_q  <= stop_prev_d;
            cnt_q        <= cnt_d;
            expire_q     <= expire_d;
            dvd_q        <= dvd_d;
            quo_q        <= quo_d;
            rem_q        <= rem_d;
            step_q       <= step_d;
            digits_q     <= digits_d;
            dash_q       <= dash_d;
            dp_on_q      <= dp_on_d;
        end
    end

    // One digit lit per slot keeps the cathode current low
    logic [15:0] mux_cnt_q, mux_cnt_d;
    logic [1:0]  sel_q, sel_d;
    logic [6:0]  seg_d;
    logic        dp_d;
    logic [3:0]  digit_n_d;

    always_comb begin
        mux_cnt_d = mux_cnt_q + 16'h1;
        sel_d     = sel_q;
        if (mux_cnt_q >= 16'(MUX_CYC - 1)) begin
            mux_cnt_d = 16'h0;
            sel_d     = sel_q + 2'h1;
        end
        digit_n_d = ~(4'h1 << sel_q);
        if (dash_q) begin
            seg_d = SEG_DASH;
            dp_d  = 1'b0;
        end else begin
            seg_d = seg_of(digits_q[sel_q]);
            dp_d  = dp_on_q && (sel_q == 2'(DP_DIGIT));
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mux_cnt_q <= 16'h0;
            sel_q     <= 2'h0;
            seg_q     <= SEG_BLANK;
            dp_q      <= 1'b0;
            digit_n_q <= DIG_ALL_OFF_N;
        end else begin
            mux_cnt_q <= mux_cnt_d;
            sel_q     <= sel_d;
            seg_q     <= seg_d;
            dp_q      <= dp_d;
            digit_n_q <= digit_n_d;
        end
    end

endmodule

/* File: include/pst_pkg.sv */
package pst_pkg;

    // System clock
    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned CLK_KHZ       = CLK_HZ / 1000;

    // Comparator enable delay after power-on
    localparam int unsigned POR_US        = 4;
    localparam int unsigned POR_CYC       = (POR_US * CLK_HZ + 999_999)
                                            / 1_000_000;

    // Sensor geometry and speed limits
    localparam int unsigned SPACING_MM    = 300;
    localparam int unsigned MAX_SPEED_MPS = 1500;
    localparam int unsigned MIN_CYC       = CLK_KHZ * SPACING_MM
                                            / MAX_SPEED_MPS;
    // Speed in tenths of m/s = SPEED_NUM / interval cycles
    localparam int unsigned SPEED_NUM     = CLK_KHZ * SPACING_MM * 10;
    localparam int unsigned SPEED_NUM_W   = 27;
    localparam int unsigned SPEED_W       = 14;

    // Measurement timeouts
    localparam int unsigned TIMEOUT_MS    = 330;
    localparam int unsigned TIMEOUT_CYC   = TIMEOUT_MS * CLK_KHZ;
    localparam int unsigned HOLDOFF_MS    = 2000;
    localparam int unsigned HOLDOFF_CYC   = HOLDOFF_MS * CLK_KHZ;
    localparam int unsigned EXPIRE_S      = 60;
    localparam longint unsigned EXPIRE_CYC_L = 64'(EXPIRE_S) * 64'(CLK_HZ);

    // Display multiplex slot per digit
    localparam int unsigned MUX_US        = 100;
    localparam int unsigned MUX_CYC       = MUX_US * CLK_KHZ / 1000;

    // Segment patterns, bit order g..a, active high
    localparam logic [6:0] SEG_DASH       = 7'h40;
    localparam logic [6:0] SEG_BLANK      = 7'h00;
    localparam int unsigned DP_DIGIT      = 1;
    localparam logic [3:0] DIG_ALL_OFF_N  = 4'hf;

    typedef enum logic [2:0] {
        PST_POR,
        PST_ARMED,
        PST_TIMING,
        PST_DIVIDE,
        PST_SHOW,
        PST_HOLD
    } pst_state_t;

endpackage

/* File: testbench/pst_chk.sv */
`timescale 1ns/1ps
module pst_chk
    import pst_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic [2:0] start_cmp_first,
    input wire logic [2:0] start_cmp_second,
    input wire logic [2:0] stop_cmp_first,
    input wire logic [2:0] stop_cmp_second,
    input wire logic       start_line,
    input wire logic       stop_line,
    input wire logic [6:0] seg_q,
    input wire logic       dp_q,
    input wire logic [3:0] digit_n_q
);
    // Margin around the enable edge, its exact cycle is the design's choice
    int unsigned up_q;
    int unsigned up_d;
    logic [3:0]  dig_q;
    logic [3:0]  dig_d;
    always_comb begin
        up_d  = rst ? 0 : up_q + 32'(up_q < POR_CYC + 4);
        dig_d = digit_n_q;
    end
    always_ff @(posedge sys_clk) begin
        up_q  <= up_d;
        dig_q <= dig_d;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_new_digit;
        $changed(digit_n_q) && digit_n_q != DIG_ALL_OFF_N;
    endsequence
    AST_START_OR: assert property (
        up_q > POR_CYC + 2 |->
        start_line == |{start_cmp_first, start_cmp_second})
        else $error("start line wrong");
    AST_STOP_OR: assert property (
        up_q > POR_CYC + 2 |->
        stop_line == |{stop_cmp_first, stop_cmp_second})
        else $error("stop line wrong");
    AST_PRE_EN: assert property (
        up_q + 2 < POR_CYC |-> !start_line && !stop_line)
        else $error("line high before enable");
    AST_RST_DISP: assert property (
        $fell(rst) |->
        digit_n_q == DIG_ALL_OFF_N && seg_q == SEG_BLANK && !dp_q)
        else $error("display not cleared by reset");
    AST_ONE_DIGIT: assert property (
        $countones(~digit_n_q) <= 1)
        else $error("several digits on");
    AST_SLOT: assert property (
        s_new_digit |=> $stable(digit_n_q)[*8])
        else $error("digit slot too short");
    AST_ROTATE: assert property (
        digit_n_q != dig_q && dig_q != DIG_ALL_OFF_N &&
        digit_n_q != DIG_ALL_OFF_N |-> digit_n_q == {dig_q[2:0], dig_q[3]})
        else $error("digit order wrong");
    AST_DP_DIGIT: assert property (
        dp_q |-> digit_n_q == 4'hd)
        else $error("point on wrong digit");
endmodule

/* File: testbench/pst_sensor_model.sv */
`timescale 1ns/1ps
module pst_sensor_model (
    input  wire logic       sys_clk,
    input  wire logic       shot,
    input  wire integer     gap,
    input  wire logic [5:0] man_start,
    input  wire logic [5:0] man_stop,
    output logic [2:0]      start_cmp_first,
    output logic [2:0]      start_cmp_second,
    output logic [2:0]      stop_cmp_first,
    output logic [2:0]      stop_cmp_second
);
    // Stop beam on the first chip so it must pass the chain
    int         cnt_q = 0;
    logic       run_q = 1'b0;
    logic [5:0] a_q   = 6'h00;
    logic [5:0] b_q   = 6'h00;
    always @(posedge sys_clk) begin
        run_q <= shot || (run_q && cnt_q < gap + 3);
        cnt_q <= shot ? 0 : cnt_q + 1;
        a_q   <= man_start | ((shot || (run_q && cnt_q < 2)) ? 6'h10 : 6'h00);
        if (run_q && gap != 0 && cnt_q + 1 >= gap && cnt_q < gap + 2) begin
            b_q <= man_stop | 6'h01;
        end else begin
            b_q <= man_stop;
        end
    end
    assign {start_cmp_second, start_cmp_first} = a_q;
    assign {stop_cmp_second, stop_cmp_first}   = b_q;
endmodule

/* File: testbench/projectile_speed_timer_tb_top.sv */
`timescale 1ns/1ps
module projectile_speed_timer_tb_top
    import pst_pkg::*;
;
    localparam int EXPIRE = 25000;
    localparam int TOUT   = 15000;
    logic       sys_clk    = 1'b0;
    logic       rst        = 1'b1;
    logic       shot       = 1'b0;
    int         gap        = 0;
    int         cyc        = 0;
    int         tl;
    int         mismatches = 0;
    int         n_checks   = 0;
    logic [5:0] man_start  = 6'h00;
    logic [5:0] man_stop   = 6'h00;
    logic [2:0] scf, scs, pcf, pcs;
    logic       start_line, stop_line, dp_q;
    logic [6:0] seg_q;
    logic [3:0] digit_n_q;
    logic [6:0] got_seg [4];
    logic       got_dp [4];
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    pst_sensor_model partner (.sys_clk(sys_clk), .shot(shot), .gap(gap),
        .man_start(man_start), .man_stop(man_stop), .start_cmp_first(scf),
        .start_cmp_second(scs), .stop_cmp_first(pcf), .stop_cmp_second(pcs));
    pst_top #(.HOLDOFF_CYCLES(200), .EXPIRE_CYCLES(EXPIRE),
        .TIMEOUT_CYCLES(TOUT), .MIN_CYCLES(MIN_CYC)) dut (.sys_clk(sys_clk),
        .rst(rst), .start_cmp_first(scf), .start_cmp_second(scs),
        .stop_cmp_first(pcf), .stop_cmp_second(pcs),
        .start_line(start_line), .stop_line(stop_line), .seg_q(seg_q),
        .dp_q(dp_q), .digit_n_q(digit_n_q));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // Capture every digit in mask during its own slot
    task automatic grab(input logic [3:0] mask);
        logic [3:0] seen;
        seen = 4'h0;
        for (int k = 0; k < 20000 && seen != mask; k++) begin
            @(negedge sys_clk);
            for (int i = 0; i < 4; i++) begin
                if (mask[i] && digit_n_q === ~(4'h1 << i)) begin
                    got_seg[i] = seg_q;
                    got_dp[i]  = dp_q;
                    seen[i]    = 1'b1;
                end
            end
        end
        if (seen != mask) begin
            mismatches++;
            wrap_up();
        end
    endtask
    task automatic show(input logic [27:0] segs, input logic [3:0] dps);
        grab(4'hf);
        for (int i = 0; i < 4; i++) begin
            check({got_dp[i], got_seg[i]}, {dps[i], segs[i*7 +: 7]});
        end
    endtask
    function automatic logic [7:0] pick(input logic stop_side);
        pick = {7'h00, stop_side ? stop_line : start_line};
    endfunction
    task automatic chan(input logic stop_side);
        for (int b = 0; b < 6; b++) begin
            tick(1);
            if (stop_side) man_stop <= 6'h01 << b;
            else man_start <= 6'h01 << b;
            tick(2);
            #1 check(pick(stop_side), 8'h01);
            tick(1);
            man_stop  <= 6'h00;
            man_start <= 6'h00;
            tick(2);
            #1 check(pick(stop_side), 8'h00);
        end
    endtask
    // Stop comes gap cycles after start; gap 0 means no stop at all
    task automatic fly(input int n);
        tick(1);
        shot <= 1'b1;
        gap  <= n;
        tick(1);
        shot <= 1'b0;
        tick(n + 40);
    endtask
    task automatic t_power;
        man_start <= 6'h3f;
        tick(100);
        #1 check({7'h00, start_line}, 8'h00);
        tick(1);
        man_start <= 6'h00;
        tick(100);
        show({4{SEG_DASH}}, 4'h0);
    endtask
    task automatic t_tenths;
        fly(14400);
        tl = cyc;
        chan(1'b0);
        fly(100);
        tick(100);
        show({7'h7f, {3{7'h4f}}}, 4'h2);
        tick(tl + EXPIRE + 100 - cyc);
        #1 check({dp_q, seg_q}, {1'b0, SEG_DASH});
    endtask
    task automatic t_whole;
        fly(8500);
        tick(100);
        show({7'h06, 7'h66, 7'h06, 7'h06}, 4'h0);
    endtask
    task automatic t_zero_timeout;
        fly(4000);
        tick(300);
        #1 check({dp_q, seg_q}, {1'b0, 7'h3f});
        fly(0);
        tick(TOUT + 100);
        #1 check({dp_q, seg_q}, {1'b0, SEG_DASH});
        // Starts inside a hold-off window: a timeout must not add one
        fly(4000);
        tick(100);
        #1 check({dp_q, seg_q}, {1'b0, 7'h3f});
    endtask
    initial begin
        tick(2);
        rst <= 1'b0;
        t_power();
        chan(1'b1);
        t_tenths();
        t_whole();
        t_zero_timeout();
        wrap_up();
    end
endmodule
bind pst_top pst_chk chk (.sys_clk(sys_clk), .rst(rst),
    .start_cmp_first(start_cmp_first), .start_cmp_second(start_cmp_second),
    .stop_cmp_first(stop_cmp_first), .stop_cmp_second(stop_cmp_second),
    .start_line(start_line), .stop_line(stop_line), .seg_q(seg_q),
    .dp_q(dp_q), .digit_n_q(digit_n_q));
